/* verilog/dmwp_engine.sv */
// debug memory write policy engine with access delays and AXI4-Lite registers
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/100ps

// Summary of operation
// - copy-back data write hit updates cache line only and marks it dirty.
// - copy-back data write miss writes physical memory only.
// - write-through data hit updates cache and memory.
// - write-through data miss writes memory only.
// - bypass data write goes to memory only, cache ignored.
// - code download writes memory and invalidates each enabled cache at that address.
// - unspecified write type is handled as instruction write.
// - both caches off: instruction write goes to memory, policy ignored.
// - instruction cache off: write memory, data cache per instruction policy.
// - update-instr bypass-data: icache hit updated with memory, dcache untouched.
// - update-both: hits update both caches and memory.
// - invalidate-instr bypass-data: invalidate icache line, memory only.
// - invalidate-instr update-data: invalidate icache, write memory, update dcache hit.
// - cycle read delay is count over core frequency, default none.
// - cycle write delay is count over core frequency, default none.
// - microsecond read delay up to ten million, default none.
// - microsecond write delay up to ten million, default none.
// - cache enable bits come from the hardware implementation register.
// - data cache off: data write goes to memory, policy ignored.
module dmwp_engine
  import dmwp_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // axi4-lite slave
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // debugger request side
  input wire dmwp_req_t i_req,
  input wire logic i_req_valid,
  output logic o_req_ready,
  output logic o_done,
  output logic [31:0] o_rd_data,
  // core side: cache lookup
  output logic o_lookup,
  output logic [31:0] o_lookup_addr,
  input wire logic i_lookup_done,
  input wire logic i_ihit,
  input wire logic i_dhit,
  // core side: actions
  output dmwp_act_t o_act,
  output logic o_act_valid,
  input wire logic i_act_done,
  input wire logic [31:0] i_act_rdata
);

  // ==========================================================
  // registers
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_LOOK = 5'b00010,
    ST_ACT = 5'b00100,
    ST_WAIT = 5'b01000,
    ST_DONE = 5'b10000
  } dmwp_st_t;

  dmwp_st_t st_r, st_nxt;
  dmwp_req_t req_r;
  dmwp_act_t act_r;
  logic [31:0] ctrl_r, rcyc_r, wcyc_r, freq_r, rus_r, wus_r, himpl_r;
  logic [31:0] rdat_r;
  logic [63:0] cnt_r;
  logic aw_got_r, w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bad_r;

  // ==========================================================
  // register bus
  wire aw_hs = i_awvalid & o_awready;
  wire w_hs = i_wvalid & o_wready;
  wire [7:0] wa = aw_hs ? i_awaddr : aw_addr_r;
  wire [31:0] wd = w_hs ? i_wdata : w_data_r;
  wire wr_go = (aw_got_r | aw_hs) & (w_got_r | w_hs) & ~o_bvalid;
  // strobes are kept with the data so an early w beat still merges bytes
  wire [3:0] ws = w_hs ? i_wstrb : w_strb_r;
  wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  // registers only change between accesses so a running delay stays consistent
  wire cfg_ok = st_r == ST_IDLE;
  wire wr_hit = (wa == ADDR_CTRL) | (wa == ADDR_RCYC) | (wa == ADDR_WCYC) | (wa == ADDR_FREQ)
    | (wa == ADDR_RUS) | (wa == ADDR_WUS) | (wa == ADDR_HIMPL);
  wire [31:0] wv_ctrl = (ctrl_r & ~wmask) | (wd & wmask);
  wire [31:0] wv_rcyc = (rcyc_r & ~wmask) | (wd & wmask);
  wire [31:0] wv_wcyc = (wcyc_r & ~wmask) | (wd & wmask);
  wire [31:0] wv_freq = (freq_r & ~wmask) | (wd & wmask);
  wire [31:0] wv_rus = (rus_r & ~wmask) | (wd & wmask);
  wire [31:0] wv_wus = (wus_r & ~wmask) | (wd & wmask);
  wire [31:0] wv_hi = (himpl_r & ~wmask) | (wd & wmask);
  wire range_ok = (wa == ADDR_FREQ) ? (wv_freq >= FREQ_MIN && wv_freq <= FREQ_MAX)
    : (wa == ADDR_RCYC) ? (wv_rcyc <= CYC_MAX)
    : (wa == ADDR_WCYC) ? (wv_wcyc <= CYC_MAX)
    : (wa == ADDR_RUS) ? (wv_rus <= US_MAX)
    : (wa == ADDR_WUS) ? (wv_wus <= US_MAX) : 1'b1;
  wire wr_ok = wr_hit & range_ok & cfg_ok;
  assign o_awready = ~aw_got_r & ~o_bvalid;
  assign o_wready = ~w_got_r & ~o_bvalid;
  assign o_arready = ~o_rvalid;

  logic [31:0] rd_mux;
  wire [31:0] stat_w = {27'h0, st_r};
  always_comb
  begin
    if (i_araddr == ADDR_CTRL) rd_mux = ctrl_r;
    else if (i_araddr == ADDR_RCYC) rd_mux = rcyc_r;
    else if (i_araddr == ADDR_WCYC) rd_mux = wcyc_r;
    else if (i_araddr == ADDR_FREQ) rd_mux = freq_r;
    else if (i_araddr == ADDR_RUS) rd_mux = rus_r;
    else if (i_araddr == ADDR_WUS) rd_mux = wus_r;
    else if (i_araddr == ADDR_STAT) rd_mux = stat_w;
    else if (i_araddr == ADDR_HIMPL) rd_mux = himpl_r;
    else rd_mux = ZERO32;
  end
  wire rd_hit = (i_araddr == ADDR_CTRL) | (i_araddr == ADDR_RCYC) | (i_araddr == ADDR_WCYC)
    | (i_araddr == ADDR_FREQ) | (i_araddr == ADDR_RUS) | (i_araddr == ADDR_WUS)
    | (i_araddr == ADDR_STAT) | (i_araddr == ADDR_HIMPL);

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= ZERO32;
      w_strb_r <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
      o_rvalid <= 1'b0;
      o_rresp <= RESP_OKAY;
      o_rdata <= ZERO32;
    end
    else
    begin
      if (wr_go)
      begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else
      begin
        if (aw_hs) aw_got_r <= 1'b1;
        if (w_hs) w_got_r <= 1'b1;
        if (o_bvalid && i_bready) o_bvalid <= 1'b0;
      end
      if (aw_hs) aw_addr_r <= i_awaddr;
      if (w_hs) w_data_r <= i_wdata;
      if (w_hs) w_strb_r <= i_wstrb;
      if (i_arvalid && o_arready)
      begin
        o_rvalid <= 1'b1;
        o_rdata <= rd_mux;
        o_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (o_rvalid && i_rready) o_rvalid <= 1'b0;
    end
  end

  // cache enables live in the hardware_impl_register
  wire instr_cache_enable_bit = himpl_r[HI_ICE_BIT];
  wire dce = himpl_r[HI_DCE_BIT];
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ctrl_r <= ZERO32;
      rcyc_r <= ZERO32;
      wcyc_r <= ZERO32;
      rus_r <= ZERO32;
      wus_r <= ZERO32;
      freq_r <= FREQ_RST;
      himpl_r <= ZERO32;
    end
    else if (wr_go && wr_ok)
    begin
      if (wa == ADDR_CTRL) ctrl_r <= wv_ctrl;
      else if (wa == ADDR_RCYC) rcyc_r <= wv_rcyc;
      else if (wa == ADDR_WCYC) wcyc_r <= wv_wcyc;
      else if (wa == ADDR_FREQ) freq_r <= wv_freq;
      else if (wa == ADDR_RUS) rus_r <= wv_rus;
      else if (wa == ADDR_WUS) wus_r <= wv_wus;
      else if (wa == ADDR_HIMPL) himpl_r <= wv_hi;
    end
  end

  // ==========================================================
  // write policy decode
  wire [1:0] dpol = ctrl_r[CTRL_DPOL_LSB +: 2];
  wire [1:0] ipol = ctrl_r[CTRL_IPOL_LSB +: 2];
  wire tmode = ctrl_r[CTRL_TMODE_BIT];
  // only enabled caches can hit; lookup result is taken first
  wire ih = i_ihit & instr_cache_enable_bit;
  wire dh = i_dhit & dce;
  wire is_dl = req_r.kind == KIND_DOWNLOAD;
  wire is_data = req_r.kind == KIND_DATA;
  wire i_upd = (ipol == IPOL_UPD_DCU) || (ipol == IPOL_UPD_DCB);
  wire i_dcu = (ipol == IPOL_UPD_DCU) || (ipol == IPOL_INV_DCU);

  dmwp_act_t pol;
  always_comb
  begin
    pol = '0;
    pol.addr = req_r.addr;
    pol.data = req_r.data;
    if (!req_r.we) pol.mem_rd = 1'b1;
    else if (is_dl)
    begin
      pol.mem_wr = 1'b1;
      pol.icache_inv = instr_cache_enable_bit;
      pol.dcache_inv = dce;
    end
    else if (is_data)
    begin
      if (!dce || dpol == DPOL_BYPASS) pol.mem_wr = 1'b1;
      else if (dpol == DPOL_THRU)
      begin
        pol.mem_wr = 1'b1;
        pol.dcache_upd = dh;
      end
      else
      begin
        pol.mem_wr = ~dh;
        pol.dcache_upd = dh;
        pol.dcache_dirty = dh;
      end
    end
    else
    begin
      // unspecified kind lands here as an instruction write
      pol.mem_wr = 1'b1;
      pol.icache_upd = ih & i_upd;
      pol.icache_inv = ih & ~i_upd;
      pol.dcache_upd = dh & i_dcu;
    end
  end

  // ==========================================================
  // delay: cycles*CLK_MHZ/freq or us*CLK_MHZ probe clocks
  wire [31:0] cyc_sel = req_r.we ? wcyc_r : rcyc_r;
  wire [31:0] us_sel = req_r.we ? wus_r : rus_r;
  wire [63:0] dly_load = tmode ? (64'(us_sel) * 64'(CLK_MHZ))
    : (64'(cyc_sel) * 64'(CLK_MHZ));
  // cycle mode: take core MHz off per probe clock, so the stall is count/freq in time
  wire [63:0] dec = tmode ? 64'h1 : 64'(freq_r);

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: if (i_req_valid) st_nxt = i_req.we ? ST_LOOK : ST_ACT;
      ST_LOOK: if (i_lookup_done) st_nxt = ST_ACT;
      ST_ACT: if (i_act_done) st_nxt = ST_WAIT;
      ST_WAIT: if (cnt_r == 64'h0) st_nxt = ST_DONE;
      ST_DONE: st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_r <= ST_IDLE;
      req_r <= '0;
      act_r <= '0;
      cnt_r <= 64'h0;
      rdat_r <= ZERO32;
    end
    else
    begin
      st_r <= st_nxt;
      if (st_r == ST_IDLE && i_req_valid) req_r <= i_req;
      if (st_r == ST_IDLE && i_req_valid && !i_req.we)
        act_r <= '{mem_rd: 1'b1, addr: i_req.addr, data: i_req.data, default: 1'b0};
      if (st_r == ST_LOOK && i_lookup_done) act_r <= pol;
      if (st_r == ST_ACT && i_act_done)
      begin
        cnt_r <= dly_load;
        if (!req_r.we) rdat_r <= i_act_rdata;
      end
      if (st_r == ST_WAIT && cnt_r != 64'h0)
        cnt_r <= (cnt_r <= dec) ? 64'h0 : cnt_r - dec;
    end
  end

  // ==========================================================
  // outputs
  assign o_req_ready = st_r == ST_IDLE;
  assign o_lookup = st_r == ST_LOOK;
  assign o_lookup_addr = req_r.addr;
  assign o_act = act_r;
  assign o_act_valid = st_r == ST_ACT;
  assign o_done = st_r == ST_DONE;
  assign o_rd_data = rdat_r;

endmodule // dmwp_engine

/* verilog/dmwp_pkg.sv */
// constants, register map and types for the debug memory write policy engine
package dmwp_pkg;

  // ==========================================================
  // clock and register map
  localparam int unsigned CLK_MHZ = 250;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RCYC = 8'h04;
  localparam logic [7:0] ADDR_WCYC = 8'h08;
  localparam logic [7:0] ADDR_FREQ = 8'h0C;
  localparam logic [7:0] ADDR_RUS = 8'h10;
  localparam logic [7:0] ADDR_WUS = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam logic [7:0] ADDR_HIMPL = 8'h1C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // control fields
  localparam int unsigned CTRL_DPOL_LSB = 0;
  localparam int unsigned CTRL_IPOL_LSB = 2;
  localparam int unsigned CTRL_TMODE_BIT = 4;
  localparam int unsigned HI_ICE_BIT = 15;
  localparam int unsigned HI_DCE_BIT = 14;
  localparam logic [31:0] FREQ_RST = 32'h0000_0190;
  localparam logic [31:0] FREQ_MIN = 32'h0000_0064;
  localparam logic [31:0] FREQ_MAX = 32'h0000_02BC;
  localparam logic [31:0] CYC_MAX = 32'hEE6B_2800;
  localparam logic [31:0] US_MAX = 32'h0098_9680;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  // data write policies
  typedef enum logic [1:0] {
    DPOL_COPY_BACK_COHERENT = 2'h0,
    DPOL_THRU = 2'h1,
    DPOL_BYPASS = 2'h2
  } dmwp_dpol_t;

  // instruction write policies
  typedef enum logic [1:0] {
    IPOL_UPD_DCU = 2'h0,
    IPOL_UPD_DCB = 2'h1,
    IPOL_INV_DCB = 2'h2,
    IPOL_INV_DCU = 2'h3
  } dmwp_ipol_t;

  // access kinds from the debugger
  typedef enum logic [1:0] {
    KIND_UNSPEC = 2'h0,
    KIND_INSTR = 2'h1,
    KIND_DATA = 2'h2,
    KIND_DOWNLOAD = 2'h3
  } dmwp_kind_t;

  // debugger memory request
  typedef struct packed {
    logic we;
    dmwp_kind_t kind;
    logic [31:0] addr;
    logic [31:0] data;
  } dmwp_req_t;

  // one action set toward the core
  typedef struct packed {
    logic mem_wr;
    logic mem_rd;
    logic icache_upd;
    logic icache_inv;
    logic dcache_upd;
    logic dcache_dirty;
    logic dcache_inv;
    logic [31:0] addr;
    logic [31:0] data;
  } dmwp_act_t;

endpackage

/* tb/dmwp_engine_properties.sv */
// port assertions for the policy engine
`timescale 1ns/100ps
module dmwp_props
  import dmwp_pkg::*;
(
  // clock, reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // request and core side
  input wire dmwp_req_t i_req,
  input wire logic i_req_valid,
  input wire logic o_req_ready,
  input wire logic o_done,
  input wire logic o_lookup,
  input wire logic [31:0] o_lookup_addr,
  input wire logic i_lookup_done,
  input wire logic i_ihit,
  input wire logic i_dhit,
  input wire dmwp_act_t o_act,
  input wire logic o_act_valid,
  input wire logic i_act_done
);
  dmwp_req_t q_r;
  logic ih_r;
  logic dh_r;
  logic wr;
  logic isi;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  assign wr = o_act_valid && q_r.we;
  assign isi = q_r.kind == KIND_UNSPEC || q_r.kind == KIND_INSTR;
  always_ff @(posedge i_clk)
  begin
    if (i_req_valid && o_req_ready)
      q_r <= i_req;
    if (i_lookup_done)
      ih_r <= i_ihit;
    if (i_lookup_done)
      dh_r <= i_dhit;
  end
  // ==========================================
  // properties
  sequence s_take_wr;
    i_req_valid && o_req_ready && i_req.we && i_req.kind != KIND_DOWNLOAD;
  endsequence
  sequence s_act_end;
    o_act_valid && i_act_done;
  endsequence
  property p_lookup;
    s_take_wr |=> o_lookup && o_lookup_addr == $past(i_req.addr);
  endproperty
  a_lookup: assert property (p_lookup) else $error("no lookup");
  property p_look_act;
    o_lookup |-> !o_act_valid && !o_done;
  endproperty
  a_look_act: assert property (p_look_act) else $error("act in lookup");
  property p_late;
    s_act_end |=> !o_done;
  endproperty
  a_late: assert property (p_late) else $error("early done");
  property p_pulse;
    o_done |=> !o_done && o_req_ready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("done pulse");
  property p_read;
    o_act_valid && !q_r.we |-> o_act.mem_rd && !o_act.mem_wr;
  endproperty
  a_read: assert property (p_read) else $error("read act");
  property p_dl;
    wr && q_r.kind == KIND_DOWNLOAD |-> o_act.mem_wr && !o_act.icache_upd && !o_act.dcache_upd;
  endproperty
  a_dl: assert property (p_dl) else $error("download act");
  property p_imem;
    wr && isi |-> o_act.mem_wr && !o_act.dcache_dirty;
  endproperty
  a_imem: assert property (p_imem) else $error("instr mem");
  property p_dmiss;
    wr && q_r.kind == KIND_DATA && !dh_r |-> o_act.mem_wr && !o_act.dcache_upd;
  endproperty
  a_dmiss: assert property (p_dmiss) else $error("data miss");
  property p_imiss;
    wr && isi && !ih_r |-> !o_act.icache_upd && !o_act.icache_inv;
  endproperty
  a_imiss: assert property (p_imiss) else $error("icache miss");
  property p_hold;
    o_act_valid && !i_act_done |=> o_act_valid && $stable(o_act);
  endproperty
  a_hold: assert property (p_hold) else $error("act moved");
endmodule // dmwp_props

bind dmwp_engine dmwp_props u_props (.i_clk, .i_rst_n, .i_req, .i_req_valid, .o_req_ready,
  .o_done, .o_lookup, .o_lookup_addr, .i_lookup_done, .i_ihit, .i_dhit, .o_act,
  .o_act_valid, .i_act_done);

/* tb/dmwp_core_model.sv */
// behavioural core: cache lookup and memory actions
`timescale 1ns/100ps
module dmwp_core_model
  import dmwp_pkg::*;
(
  // clock, reset, knobs
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ihit_cfg,
  input wire logic i_dhit_cfg,
  input wire logic [1:0] i_wait,
  // engine side
  input wire logic i_lookup,
  input wire dmwp_act_t i_act,
  input wire logic i_act_valid,
  output logic o_lookup_done,
  output logic o_ihit,
  output logic o_dhit,
  output logic o_act_done,
  output logic [31:0] o_act_rdata
);
  logic [1:0] lw_r;
  logic [1:0] aw_r;
  logic lk_go;
  logic ac_go;
  assign lk_go = i_lookup && !o_lookup_done && lw_r == i_wait;
  assign ac_go = i_act_valid && !o_act_done && aw_r == i_wait;
  // idle hit and data lines toggle so stale values never look valid
  always_ff @(posedge i_clk)
  begin
    lw_r <= (i_rst_n && i_lookup && !o_lookup_done && !lk_go) ? lw_r + 2'h1 : 2'h0;
    aw_r <= (i_rst_n && i_act_valid && !o_act_done && !ac_go) ? aw_r + 2'h1 : 2'h0;
    o_lookup_done <= i_rst_n && lk_go;
    o_act_done <= i_rst_n && ac_go;
    o_ihit <= !i_rst_n ? 1'b0 : lk_go ? i_ihit_cfg : !o_ihit;
    o_dhit <= !i_rst_n ? 1'b0 : lk_go ? i_dhit_cfg : !o_dhit;
    o_act_rdata <= !i_rst_n ? 32'h0 : ac_go ? i_act.addr ^ 32'h5A5A_0F0F : ~o_act_rdata;
  end
endmodule // dmwp_core_model

/* tb/dmwp_engine_tb.sv */
// self-checking bench for the policy engine
`timescale 1ns/100ps
module dmwp_engine_tb;
  import dmwp_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_awaddr = 8'h00;
  logic [7:0] i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_awvalid = 1'b0;
  logic i_wvalid = 1'b0;
  logic i_arvalid = 1'b0;
  logic i_req_valid = 1'b0;
  dmwp_req_t i_req = '0;
  logic ihc = 1'b0;
  logic dhc = 1'b0;
  logic [1:0] wt = 2'h0;
  logic [3:0] wsb = 4'hF;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_req_ready, o_done, o_lookup;
  logic i_lookup_done, i_ihit, i_dhit, o_act_valid, i_act_done;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata, o_rd_data, o_lookup_addr, i_act_rdata;
  dmwp_act_t o_act;
  int fails = 0;
  int checked = 0;
  int lat;
  logic [6:0] seen;
  always #2 i_clk = ~i_clk;
  dmwp_engine dut (.i_clk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb(wsb), .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready(1'b1), .i_araddr,
    .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready(1'b1), .i_req,
    .i_req_valid, .o_req_ready, .o_done, .o_rd_data, .o_lookup, .o_lookup_addr,
    .i_lookup_done, .i_ihit, .i_dhit, .o_act, .o_act_valid, .i_act_done, .i_act_rdata);
  dmwp_core_model u_core (.i_clk, .i_rst_n, .i_ihit_cfg(ihc), .i_dhit_cfg(dhc), .i_wait(wt),
    .i_lookup(o_lookup), .i_act(o_act), .i_act_valid(o_act_valid),
    .o_lookup_done(i_lookup_done), .o_ihit(i_ihit), .o_dhit(i_dhit),
    .o_act_done(i_act_done), .o_act_rdata(i_act_rdata));
  // ==========================================
  // tasks
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic tick(inout int n);
    @(posedge i_clk);
    n++;
    if (n > 2000)
    begin
      fails++;
      final_report();
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw;
    logic w;
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    do
    begin
      tick(n);
      if (aw && o_awready)
        i_awvalid <= 1'b0;
      if (aw && o_awready)
        aw = 1'b0;
      if (w && o_wready)
        i_wvalid <= 1'b0;
      if (w && o_wready)
        w = 1'b0;
    end while (aw || w);
    do tick(n); while (!o_bvalid);
    check("bresp", o_bresp, er);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    i_araddr <= a;
    i_arvalid <= 1'b1;
    do tick(n); while (!o_arready);
    i_arvalid <= 1'b0;
    do tick(n); while (!o_rvalid);
    check("rdata", o_rdata, ed);
    check("rresp", o_rresp, er);
  endtask
  task automatic dbg(input logic we, input dmwp_kind_t k, input logic [31:0] a);
    int n;
    n = 0;
    i_req <= '{we: we, kind: k, addr: a, data: ~a};
    i_req_valid <= 1'b1;
    do tick(n); while (!o_req_ready);
    i_req_valid <= 1'b0;
    do tick(n); while (!(o_act_valid && i_act_done));
    seen = o_act[70:64];
    check("act_addr", o_act.addr, a);
    lat = 0;
    do
    begin
      tick(n);
      lat++;
    end while (!o_done);
    tick(n);
  endtask
  function automatic logic [6:0] exp_act(input logic we, input int k, input int p, input int c);
    logic ih;
    logic dh;
    ih = c[1] && ihc;
    dh = c[0] && dhc;
    if (!we)
      return 7'h20;
    if (k == 3)
      return {1'b1, 2'h0, c[1], 2'h0, c[0]};
    if (k == 2)
      return !dh ? 7'h40 : p == 1 ? 7'h44 : p == 2 ? 7'h40 : 7'h06;
    return {1'b1, 1'b0, ih && p < 2, ih && p > 1, dh && (p == 0 || p == 3), 2'h0};
  endfunction
  // ==========================================
  // sequence
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    axi_rd(ADDR_FREQ, FREQ_RST, RESP_OKAY);
    axi_rd(ADDR_HIMPL, ZERO32, RESP_OKAY);
    axi_rd(ADDR_RCYC, ZERO32, RESP_OKAY);
    axi_rd(ADDR_WUS, ZERO32, RESP_OKAY);
    axi_rd(ADDR_STAT, 32'h0000_0001, RESP_OKAY);
    axi_rd(8'h20, ZERO32, RESP_SLVERR);
    axi_wr(ADDR_FREQ, FREQ_MIN - 32'h1, RESP_SLVERR);
    axi_wr(ADDR_FREQ, FREQ_MAX + 32'h1, RESP_SLVERR);
    axi_wr(ADDR_WCYC, CYC_MAX + 32'h1, RESP_SLVERR);
    axi_wr(ADDR_RUS, US_MAX + 32'h1, RESP_SLVERR);
    axi_rd(ADDR_FREQ, FREQ_RST, RESP_OKAY);
    dbg(1'b0, KIND_DATA, 32'h0000_0040);
    check("rd_lat", lat, 2);
    check("rd_data", o_rd_data, 32'h0000_0040 ^ 32'h5A5A_0F0F);
    for (int c = 0; c < 4; c++)
      for (int p = 0; p < 4; p++)
      begin
        axi_wr(ADDR_HIMPL, {16'h0, c[1], c[0], 14'h0}, RESP_OKAY);
        axi_wr(ADDR_CTRL, {28'h0, p[1:0], p[1:0]}, RESP_OKAY);
        for (int h = 0; h < 4; h++)
        begin
          ihc <= h[0];
          dhc <= h[1];
          wt <= h[1:0];
          for (int k = 0; k < 4; k++)
          begin
            dbg(1'b1, dmwp_kind_t'(k), 32'h100 + k * 4);
            check("act", seen, exp_act(1'b1, k, p, c));
            check("act_i", o_act.data, ~(32'h100 + k * 4));
            check("wr_lat", lat, 2);
          end
        end
      end
    axi_wr(ADDR_FREQ, 32'h0000_00FA, RESP_OKAY);
    axi_wr(ADDR_WCYC, 32'h0000_0002, RESP_OKAY);
    axi_wr(ADDR_RCYC, 32'h0000_0003, RESP_OKAY);
    dbg(1'b1, KIND_DATA, 32'h0000_0200);
    check("wcyc_lat", lat >= 4 && lat <= 6, 1);
    dbg(1'b0, KIND_INSTR, 32'h0000_0204);
    check("rcyc_lat", lat >= 5 && lat <= 7, 1);
    axi_wr(ADDR_FREQ, 32'h0000_01F4, RESP_OKAY);
    axi_wr(ADDR_RCYC, 32'h0000_0004, RESP_OKAY);
    dbg(1'b0, KIND_DATA, 32'h0000_0210);
    check("fcyc_lat", lat, 4);
    axi_wr(ADDR_CTRL, 32'h0000_0010, RESP_OKAY);
    axi_wr(ADDR_RUS, 32'h0000_0001, RESP_OKAY);
    dbg(1'b0, KIND_DATA, 32'h0000_0208);
    check("rus_lat", lat >= 252 && lat <= 254, 1);
    dbg(1'b1, KIND_DATA, 32'h0000_020C);
    check("wus_lat", lat, 2);
    wsb <= 4'h1;
    axi_wr(ADDR_RCYC, 32'hFFFF_FF05, RESP_OKAY);
    wsb <= 4'hF;
    axi_rd(ADDR_RCYC, 32'h0000_0005, RESP_OKAY);
    final_report();
  end
endmodule // dmwp_engine_tb
